// File: dbs_pkg.sv
// shared constants and bus-cycle carrier for the data buffer steering block
package dbs_pkg;

    // ************************************************************
    // widths and timing
    // ************************************************************
    localparam int          DBS_ADDR_W      = 16;
    localparam int          DBS_DATA_W      = 8;
    localparam int          DBS_SYNC_STAGES = 2;

    // ************************************************************
    // address decode: peripheral bus space is 0x0000..0x00ff
    // ************************************************************
    localparam int          DBS_PERIPH_MSB  = 15;
    localparam int          DBS_PERIPH_LSB  = 8;
    localparam logic [7:0]  DBS_PERIPH_PAGE = 8'h00;
    localparam int          DBS_ODD_BIT     = 0;

    // ************************************************************
    // values after reset
    // ************************************************************
    localparam logic [7:0]  DBS_RST_DATA    = 8'h00;
    localparam logic        DBS_RST_OE      = 1'b0;
    localparam logic        DBS_RST_STRB_N  = 1'b1;
    localparam logic        DBS_RST_STRB    = 1'b0;
    localparam logic        DBS_DIR_HI_LO   = 1'b0;
    localparam logic        DBS_DIR_LO_HI   = 1'b1;

    // one bus cycle as seen at the pins, all high-true except *_n
    typedef struct packed {
        logic                  interrupt_acknowledge;
        logic                  io_rd;
        logic                  mem_rd;
        logic                  dma_cycle;
        logic                  wide_data;
        logic                  periph_8bit;
        logic                  wide_io_req;
        logic                  io_wide_select_n;
        logic                  internal_hit;
        logic                  byte_high_en_n;
        logic [DBS_ADDR_W-1:0] addr;
    } dbs_cycle_s;

    localparam int DBS_CYCLE_W = $bits(dbs_cycle_s);

endpackage

// File: dbs_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module dbs_sync
    import dbs_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // dbs_sync

// File: dbs_steer.sv
// data buffer steering: peripheral bus drive, byte swap and read latch strobes
// How it works
// - drive byte bus on acknowledge or internal io read
// - otherwise byte bus stays input, undriven
// - dma: swap on odd wide-data access
// - non-dma: swap on odd 8-bit peripheral cycle
// - direction high low-to-high, low high-to-low
// - direction low on dma memory reads
// - direction low on all non-dma accesses
// - read strobe on acknowledge or io read 00xx
// - low latch follows read command, low byte
// - high latch follows read command, high byte
// - non-dma wide io with select high converts to 8-bit
`timescale 1ns/1ps
module dbs_steer
    import dbs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  interrupt_acknowledge,
    input  wire logic                  io_rd,
    input  wire logic                  mem_rd,
    input  wire logic                  dma_cycle,
    input  wire logic                  wide_data,
    input  wire logic                  periph_8bit,
    input  wire logic                  wide_io_req,
    input  wire logic                  io_wide_select_n,
    input  wire logic                  internal_hit,
    input  wire logic                  byte_high_en_n,
    input  wire logic [DBS_ADDR_W-1:0] addr,
    input  wire logic [DBS_DATA_W-1:0] dev_read_data,
    input  wire logic [DBS_DATA_W-1:0] peripheral_byte_bus_in,
    output logic      [DBS_DATA_W-1:0] peripheral_byte_bus_out,
    output logic                       peripheral_byte_bus_oe,
    output logic      [DBS_DATA_W-1:0] peripheral_byte_bus_rx,
    output logic                       byte_swap_request_n,
    output logic                       swap_direction,
    output logic                       peripheral_read_strobe_n,
    output logic                       low_byte_latch_n,
    output logic                       high_byte_latch,
    output logic                       conversion_active
);

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    dbs_cycle_s              pin_cyc;
    dbs_cycle_s              cyc;
    logic [DBS_DATA_W-1:0]   rx_sync;

    assign pin_cyc = '{
        interrupt_acknowledge : interrupt_acknowledge,
        io_rd                 : io_rd,
        mem_rd                : mem_rd,
        dma_cycle             : dma_cycle,
        wide_data             : wide_data,
        periph_8bit           : periph_8bit,
        wide_io_req           : wide_io_req,
        io_wide_select_n      : io_wide_select_n,
        internal_hit          : internal_hit,
        byte_high_en_n        : byte_high_en_n,
        addr                  : addr
    };

    // control, address and byte bus all come from pins: two stages each
    dbs_sync #(
        .W (DBS_CYCLE_W)
    ) u_cyc_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pin_cyc),
        .sync_out (cyc)
    );

    dbs_sync #(
        .W (DBS_DATA_W)
    ) u_rx_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (peripheral_byte_bus_in),
        .sync_out (rx_sync)
    );

    // ************************************************************
    // decode of the synchronised cycle
    // ************************************************************
    logic periph_space;
    logic odd_addr;
    logic read_cmd;
    logic convert;
    logic narrow_target;

    always_comb begin
        periph_space  = (cyc.addr[DBS_PERIPH_MSB:DBS_PERIPH_LSB] == DBS_PERIPH_PAGE);
        odd_addr      = cyc.addr[DBS_ODD_BIT];
        read_cmd      = cyc.io_rd | cyc.mem_rd;
        // a non-dma wide io request whose select comes back high is run as 8-bit
        convert       = cyc.wide_io_req & cyc.io_wide_select_n & ~cyc.dma_cycle;
        narrow_target = cyc.periph_8bit | convert;
    end

    // ************************************************************
    // output registers
    // ************************************************************
    logic [DBS_DATA_W-1:0] bus_out_r,  bus_out_nxt;
    logic                  bus_oe_r,   bus_oe_nxt;
    logic [DBS_DATA_W-1:0] rx_r,       rx_nxt;
    logic                  swap_n_r,   swap_n_nxt;
    logic                  dir_r,      dir_nxt;
    logic                  rd_strb_n_r, rd_strb_n_nxt;
    logic                  lat_lo_n_r, lat_lo_n_nxt;
    logic                  lat_hi_r,   lat_hi_nxt;
    logic                  conv_r,     conv_nxt;

    always_comb begin
        bus_out_nxt   = DBS_RST_DATA;
        bus_oe_nxt    = DBS_RST_OE;
        rx_nxt        = rx_sync;
        swap_n_nxt    = DBS_RST_STRB_N;
        dir_nxt       = DBS_DIR_HI_LO;
        rd_strb_n_nxt = DBS_RST_STRB_N;
        lat_lo_n_nxt  = DBS_RST_STRB_N;
        lat_hi_nxt    = DBS_RST_STRB;
        conv_nxt      = convert;

        // device answers acknowledge and reads of its own registers
        if (cyc.interrupt_acknowledge || (cyc.io_rd && cyc.internal_hit)) begin
            bus_oe_nxt  = 1'b1;
            bus_out_nxt = dev_read_data;
        end

        if (cyc.dma_cycle) begin
            if (odd_addr && cyc.wide_data) begin
                swap_n_nxt = 1'b0;
            end
            // dma memory reads move high to low; other dma transfers low to high
            dir_nxt = cyc.mem_rd ? DBS_DIR_HI_LO : DBS_DIR_LO_HI;
        end else begin
            if (odd_addr && narrow_target && (read_cmd || cyc.io_rd)) begin
                swap_n_nxt = 1'b0;
            end
            dir_nxt = DBS_DIR_HI_LO;
        end

        if (cyc.interrupt_acknowledge || (cyc.io_rd && periph_space)) begin
            rd_strb_n_nxt = 1'b0;
        end

        // latches track the read command so they drop when it drops
        if (read_cmd && !odd_addr) begin
            lat_lo_n_nxt = 1'b0;
        end
        if (read_cmd && (odd_addr || !cyc.byte_high_en_n)) begin
            lat_hi_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_out_r   <= DBS_RST_DATA;
            bus_oe_r    <= DBS_RST_OE;
            rx_r        <= DBS_RST_DATA;
            swap_n_r    <= DBS_RST_STRB_N;
            dir_r       <= DBS_DIR_HI_LO;
            rd_strb_n_r <= DBS_RST_STRB_N;
            lat_lo_n_r  <= DBS_RST_STRB_N;
            lat_hi_r    <= DBS_RST_STRB;
            conv_r      <= 1'b0;
        end else begin
            bus_out_r   <= bus_out_nxt;
            bus_oe_r    <= bus_oe_nxt;
            rx_r        <= rx_nxt;
            swap_n_r    <= swap_n_nxt;
            dir_r       <= dir_nxt;
            rd_strb_n_r <= rd_strb_n_nxt;
            lat_lo_n_r  <= lat_lo_n_nxt;
            lat_hi_r    <= lat_hi_nxt;
            conv_r      <= conv_nxt;
        end
    end

    assign peripheral_byte_bus_out  = bus_out_r;
    assign peripheral_byte_bus_oe   = bus_oe_r;
    assign peripheral_byte_bus_rx   = rx_r;
    assign byte_swap_request_n      = swap_n_r;
    assign swap_direction           = dir_r;
    assign peripheral_read_strobe_n = rd_strb_n_r;
    assign low_byte_latch_n         = lat_lo_n_r;
    assign high_byte_latch          = lat_hi_r;
    assign conversion_active        = conv_r;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_ack_seen;
        cyc.interrupt_acknowledge;
    endsequence

    sequence s_drive_next;
        ##1 (bus_oe_r && bus_out_r == $past(dev_read_data));
    endsequence

    property p_drive_on_ack;
        @(posedge clk) disable iff (sys_rst)
        s_ack_seen |-> s_drive_next;
    endproperty
    a_drive_on_ack: assert property (p_drive_on_ack)
        else $error("byte bus not driven after acknowledge");

    property p_no_drive;
        @(posedge clk) disable iff (sys_rst)
        !(cyc.interrupt_acknowledge || (cyc.io_rd && cyc.internal_hit)) |=> !bus_oe_r;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("byte bus driven outside a qualifying cycle");

    property p_dma_swap;
        @(posedge clk) disable iff (sys_rst)
        (cyc.dma_cycle && cyc.addr[DBS_ODD_BIT] && cyc.wide_data) |=> !byte_swap_request_n;
    endproperty
    a_dma_swap: assert property (p_dma_swap)
        else $error("no swap request on odd wide dma access");

    property p_cpu_swap;
        @(posedge clk) disable iff (sys_rst)
        (!cyc.dma_cycle && cyc.periph_8bit && cyc.addr[DBS_ODD_BIT] && read_cmd)
            |=> !byte_swap_request_n;
    endproperty
    a_cpu_swap: assert property (p_cpu_swap)
        else $error("no swap request on odd 8-bit peripheral cycle");

    property p_dma_rd_dir;
        @(posedge clk) disable iff (sys_rst)
        (cyc.dma_cycle && cyc.mem_rd) |=> (swap_direction == DBS_DIR_HI_LO);
    endproperty
    a_dma_rd_dir: assert property (p_dma_rd_dir)
        else $error("direction not high-to-low on dma memory read");

    property p_cpu_dir;
        @(posedge clk) disable iff (sys_rst)
        !cyc.dma_cycle |=> (swap_direction == DBS_DIR_HI_LO);
    endproperty
    a_cpu_dir: assert property (p_cpu_dir)
        else $error("direction not low on non-dma access");

    property p_read_strobe;
        @(posedge clk) disable iff (sys_rst)
        (cyc.io_rd && periph_space) |=> !peripheral_read_strobe_n;
    endproperty
    a_read_strobe: assert property (p_read_strobe)
        else $error("read strobe missing on peripheral io read");

    property p_low_latch;
        @(posedge clk) disable iff (sys_rst)
        $fell(read_cmd) |=> (low_byte_latch_n && !high_byte_latch);
    endproperty
    a_low_latch: assert property (p_low_latch)
        else $error("latch strobe outlived the read command");

    property p_idle;
        @(posedge clk) disable iff (sys_rst)
        (!read_cmd && !cyc.interrupt_acknowledge && !cyc.dma_cycle)
            |=> (byte_swap_request_n && peripheral_read_strobe_n && low_byte_latch_n);
    endproperty
    a_idle: assert property (p_idle)
        else $error("strobe active with no bus cycle");

    property p_convert;
        @(posedge clk) disable iff (sys_rst)
        (!cyc.dma_cycle && cyc.wide_io_req && cyc.io_wide_select_n) |=> conversion_active;
    endproperty
    a_convert: assert property (p_convert)
        else $error("conversion not flagged for narrow io target");

endmodule // dbs_steer

// File: dbs_buffer_model.sv
// external data buffer model: resolves the byte bus and latches read bytes
`timescale 1ns/1ps
module dbs_buffer_model
    import dbs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  bus_oe,
    input  wire logic [DBS_DATA_W-1:0] bus_out,
    input  wire logic [DBS_DATA_W-1:0] host_data,
    input  wire logic                  low_latch_n,
    input  wire logic                  high_latch,
    output logic      [DBS_DATA_W-1:0] bus_level,
    output logic      [DBS_DATA_W-1:0] low_q,
    output logic      [DBS_DATA_W-1:0] high_q
);
    // ****************************************
    // bus resolution and read latches
    // ****************************************
    // buffer side drives only while the device leaves the bus as input
    assign bus_level = bus_oe ? bus_out : host_data;

    always_ff @(posedge clk) begin
        if (!low_latch_n)
            low_q <= bus_level;
        if (high_latch)
            high_q <= bus_level;
    end
endmodule // dbs_buffer_model

// File: dbs_steer_bench.sv
// self-checking bench for the data buffer steering block
`timescale 1ns/1ps
module dbs_steer_bench
    import dbs_pkg::*;
;
    logic                  clk;
    logic                  sys_rst;
    dbs_cycle_s            cyc;
    logic [DBS_DATA_W-1:0] dev_data, host_data, bus_level, bus_out, rx, low_q, high_q;
    logic                  oe, swap_n, dir, rd_n, lo_n, hi, conv;
    logic [6:0]            got;
    int                    bad_count;
    int                    checks_done;
    // flags: ack io mem dma wide p8 wreq wsel_n hit bhe_n | addr | oe swap_n dir rd_n lo_n hi conv
    logic [32:0]           tab [13] = '{
        {10'b0000000101, 16'h0000, 7'b0101100}, {10'b1000000101, 16'h0000, 7'b1100100},
        {10'b0100010111, 16'h0061, 7'b1000110}, {10'b0100010111, 16'h0060, 7'b1100000},
        {10'b0100010101, 16'h0100, 7'b0101000}, {10'b0100000101, 16'h00ff, 7'b0100110},
        {10'b0010010101, 16'h1235, 7'b0001110}, {10'b0011100101, 16'h0003, 7'b0001110},
        {10'b0011000101, 16'h0003, 7'b0101110}, {10'b0001100101, 16'h0003, 7'b0011100},
        {10'b0100001101, 16'h0301, 7'b0001111}, {10'b0100001001, 16'h0301, 7'b0101110},
        {10'b0010000100, 16'h2000, 7'b0101010}};

    assign got = {oe, swap_n, dir, rd_n, lo_n, hi, conv};

    dbs_steer DUT (.clk(clk), .sys_rst(sys_rst),
        .interrupt_acknowledge(cyc.interrupt_acknowledge), .io_rd(cyc.io_rd),
        .mem_rd(cyc.mem_rd), .dma_cycle(cyc.dma_cycle), .wide_data(cyc.wide_data),
        .periph_8bit(cyc.periph_8bit), .wide_io_req(cyc.wide_io_req),
        .io_wide_select_n(cyc.io_wide_select_n), .internal_hit(cyc.internal_hit),
        .byte_high_en_n(cyc.byte_high_en_n), .addr(cyc.addr), .dev_read_data(dev_data),
        .peripheral_byte_bus_in(bus_level), .peripheral_byte_bus_out(bus_out),
        .peripheral_byte_bus_oe(oe), .peripheral_byte_bus_rx(rx),
        .byte_swap_request_n(swap_n), .swap_direction(dir),
        .peripheral_read_strobe_n(rd_n), .low_byte_latch_n(lo_n),
        .high_byte_latch(hi), .conversion_active(conv));

    dbs_buffer_model buffer (.clk(clk), .bus_oe(oe), .bus_out(bus_out),
        .host_data(host_data), .low_latch_n(lo_n), .high_latch(hi),
        .bus_level(bus_level), .low_q(low_q), .high_q(high_q));

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [6:0] e, input string m);
        checks_done++;
        if (got !== e) begin
            bad_count++;
            $display("FAIL %0t %s got %b want %b", $time, m, got, e);
        end
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %0t %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // generous: the sequence needs about 140 cycles
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        $display("FAIL %0t watchdog expired", $time);
        end_sim;
    end

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        cyc = dbs_cycle_s'(tab[0][32:7]);
        dev_data = 8'h00;
        host_data = 8'h00;
        repeat (10) @(negedge clk);
        chk(7'b0101100, "reset outputs");
        chk8(bus_out, DBS_RST_DATA, "reset byte out");
        sys_rst = 1'b0;
        for (int i = 0; i < 13; i++) begin
            cyc = dbs_cycle_s'(tab[i][32:7]);
            dev_data = 8'h30 + 8'(i);
            host_data = 8'hc0 + 8'(i);
            repeat (8) @(negedge clk);
            chk(tab[i][6:0], "row outputs");
            chk8(rx, tab[i][6] ? dev_data : host_data, "byte bus");
            if (tab[i][6])
                chk8(bus_out, dev_data, "driven byte");
            if (tab[i][6] && !tab[i][2])
                chk8(low_q, dev_data, "low latch data");
            if (tab[i][6] && tab[i][1])
                chk8(high_q, dev_data, "high latch data");
        end
        $display("table rows done");
        // exact latency: two sync stages then the output register, so the
        // third rising edge after a change shows it and the second does not
        cyc = dbs_cycle_s'(tab[0][32:7]);
        repeat (8) @(negedge clk);
        cyc = dbs_cycle_s'(tab[3][32:7]);
        repeat (2) @(negedge clk);
        chk(7'b0101100, "strobe too early");
        @(negedge clk);
        chk(7'b1100000, "strobe too late");
        cyc = dbs_cycle_s'(tab[0][32:7]);
        repeat (2) @(negedge clk);
        chk(7'b1100000, "strobe released early");
        @(negedge clk);
        chk(7'b0101100, "strobe held after read");
        $display("latency test done");
        // reset in mid-cycle drops everything, then the cycle comes back
        cyc = dbs_cycle_s'(tab[2][32:7]);
        repeat (8) @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        chk(7'b0101100, "mid reset outputs");
        chk8(bus_out, DBS_RST_DATA, "mid reset byte out");
        sys_rst = 1'b0;
        @(negedge clk);
        chk(7'b0101100, "first edge after reset");
        repeat (3) @(negedge clk);
        chk(7'b1000110, "cycle after reset");
        $display("reset test done");
        end_sim;
    end
endmodule // dbs_steer_bench
